// file: logic/fmd_core.sv
// Fault, warm-up, teach and display control of the flow monitor
`timescale 1ns/100ps
module fmd_core
  import fmd_pkg::*;
#(
  parameter int WARM_CYC = FIX_WAIT_S * CLK_HZ,
  parameter int STEP = 16
)(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic btn_store,
  input wire logic btn_inc,
  input wire logic btn_sel,
  input wire logic [9:0] flow,
  input wire logic gradient_check,
  input wire logic [7:0] temp_c,
  input wire logic [ERR_W-1:0] err_in,
  input wire logic has_loop,
  input wire logic bus_active,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic [9:0] req_data,
  output logic rsp_valid,
  output logic rsp_ack,
  output logic [15:0] rsp_data,
  input wire logic hart_en,
  input wire logic hart_bit,
  output logic hart_tone,
  output logic out_flow,
  output logic out_temp,
  output logic out_fault,
  output logic loop_en,
  output logic led_pwr,
  output logic led_flow,
  output logic led_temp,
  output logic led_fault,
  output logic [BAR_N-1:0] bar_green,
  output logic [BAR_N-1:0] bar_yellow,
  output logic [15:0] process_image,
  output logic warming
);
  if (STEP < 1 || STEP > 1023 || WARM_CYC < 1) begin : g_bad_param
    $error("fmd_core: bad parameter");
  end

  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] btn_s1, btn_s2, btn_q;
  logic grad_s1, grad_s2;
  always_ff @(posedge clk_sys) begin
    btn_s1 <= {btn_store, btn_inc, btn_sel};
    btn_s2 <= btn_s1;
    btn_q <= btn_s2;
    grad_s1 <= gradient_check;
    grad_s2 <= grad_s1;
  end
  wire both = btn_s2[1] & btn_s2[0];
  wire store_p = btn_s2[2] & ~btn_q[2];
  wire inc_p = btn_s2[1] & ~btn_q[1] & ~btn_s2[0];
  wire sel_p = btn_s2[0] & ~btn_q[0] & ~btn_s2[1];
  wire both_p = both & ~(btn_q[1] & btn_q[0]);

  // ****************************************
  // Error collection and latches
  // ****************************************
  logic gen_dead;
  // Only power-up initialisation clears the loop latch
  logic loop_dead = 1'b0;
  wire [ERR_W-1:0] err_all = err_in;
  wire any_err = |err_all;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gen_dead <= 1'b0;
    end else if (err_in[ERR_GENERAL]) begin
      gen_dead <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (err_in[ERR_LOOP]) loop_dead <= 1'b1;
  end

  // ****************************************
  // Mode machine
  // ****************************************
  fmd_state_t state, next_state;
  logic [31:0] warm_cnt;
  logic [9:0] span_lo, span_hi, flow_sp, temp_sp, edit;
  logic [1:0] step;
  logic quick_mode;
  wire fix_done = warm_cnt >= 32'(WARM_CYC);
  wire steady = grad_s2;
  assign warming = (state == FMD_WARM);

  always_comb begin
    next_state = state;
    case (state)
      FMD_WARM: if (fix_done && steady) next_state = FMD_SHOW;
      FMD_SHOW: begin
        if (sel_p) next_state = FMD_TEACH;
        else if (store_p) next_state = FMD_QUICK;
      end
      FMD_TEACH: begin
        if (both_p) next_state = FMD_SHOW;
        else if (store_p && steady && step == 2'd2) next_state = FMD_SHOW;
      end
      FMD_QUICK: begin
        if (both_p) next_state = FMD_SHOW;
        else if (store_p && steady) next_state = FMD_SHOW;
      end
      default: next_state = FMD_WARM;
    endcase
  end

  wire edit_ok = !bus_active;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state <= FMD_WARM;
      warm_cnt <= 32'h0000_0000;
      span_lo <= SPAN_LO_RST;
      span_hi <= SPAN_HI_RST;
      flow_sp <= FLOW_SP_RST;
      temp_sp <= TEMP_SP_RST;
      edit <= 10'h000;
      step <= 2'd0;
      quick_mode <= 1'b0;
    end else begin
      state <= next_state;
      if (!fix_done) warm_cnt <= warm_cnt + 32'h0000_0001;
      if (state == FMD_SHOW && sel_p) begin
        step <= 2'd0;
        edit <= span_lo;
      end else if (state == FMD_SHOW && store_p) begin
        edit <= flow;
      end else if (state == FMD_TEACH && !both) begin
        if (inc_p) edit <= (edit > 10'h3ff - 10'(STEP)) ? 10'h3ff : edit + 10'(STEP);
        if (sel_p) step <= step + 2'd1;
        if (store_p && steady && edit_ok) begin
          case (step)
            2'd0: span_lo <= flow;
            2'd1: span_hi <= flow;
            default: temp_sp <= edit;
          endcase
          step <= step + 2'd1;
          edit <= temp_sp;
          quick_mode <= 1'b0;
        end
      end else if (state == FMD_QUICK && store_p && steady && edit_ok) begin
        flow_sp <= flow;
        quick_mode <= 1'b1;
      end
      if (req_valid && req_write && state != FMD_WARM) begin
        if (req_index == PAR_SPAN_LO) span_lo <= req_data;
        else if (req_index == PAR_SPAN_HI) span_hi <= req_data;
        else if (req_index == PAR_FLOW_SP) flow_sp <= req_data;
        else if (req_index == PAR_TEMP_SP) temp_sp <= req_data;
      end
    end
  end

  // ****************************************
  // Parameter request and answer
  // ****************************************
  wire idx_ok = req_index == PAR_SPAN_LO || req_index == PAR_SPAN_HI ||
                req_index == PAR_FLOW_SP || req_index == PAR_TEMP_SP ||
                (req_index == PAR_STATUS && !req_write);
  wire [15:0] rd_val = (req_index == PAR_SPAN_LO) ? {6'h00, span_lo} :
                       (req_index == PAR_SPAN_HI) ? {6'h00, span_hi} :
                       (req_index == PAR_FLOW_SP) ? {6'h00, flow_sp} :
                       (req_index == PAR_TEMP_SP) ? {6'h00, temp_sp} :
                       {7'h00, err_all};
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rsp_valid <= 1'b0;
      rsp_ack <= 1'b0;
      rsp_data <= 16'h0000;
    end else begin
      rsp_valid <= req_valid;
      rsp_ack <= req_valid && idx_ok && !(req_write && state == FMD_WARM);
      rsp_data <= (req_valid && !req_write) ? rd_val : 16'h0000;
    end
  end

  // ****************************************
  // Switching outputs
  // ****************************************
  logic flow_sw, temp_sw;
  wire outs_off = warming || gen_dead;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      flow_sw <= 1'b0;
      temp_sw <= 1'b0;
      out_flow <= 1'b0;
      out_temp <= 1'b0;
      out_fault <= 1'b0;
      loop_en <= 1'b0;
    end else begin
      if (flow >= flow_sp) flow_sw <= 1'b1;
      else if ({1'b0, flow} + 11'h00a < {1'b0, flow_sp}) flow_sw <= 1'b0;
      if ({2'b00, temp_c} >= temp_sp) temp_sw <= 1'b1;
      else if ({2'b00, temp_c} + 10'h002 < temp_sp) temp_sw <= 1'b0;
      out_flow <= flow_sw && !outs_off;
      out_temp <= temp_sw && !outs_off;
      out_fault <= !any_err && !outs_off;
      loop_en <= has_loop && !outs_off && !loop_dead;
    end
  end

  // ****************************************
  // Process image and tone
  // ****************************************
  assign process_image = {flow, 3'b000, out_fault, out_temp, out_flow};

  fmd_tone fmd_tone_i (
    .clk_sys(clk_sys),
    .srst(srst),
    .enable(hart_en),
    .bit_in(hart_bit),
    .tone(hart_tone)
  );

  // ****************************************
  // Indicators
  // ****************************************
  logic [26:0] blink_cnt;
  wire blink_on = blink_cnt < 27'(BLINK_ON_CYC);
  always_ff @(posedge clk_sys) begin
    if (srst || blink_cnt >= 27'(BLINK_ON_CYC + BLINK_OFF_CYC - 1)) blink_cnt <= 27'h0;
    else blink_cnt <= blink_cnt + 27'h1;
  end
  wire diag_blink = bus_active && (any_err && !err_in[ERR_GENERAL]);
  // Even blink so a diagnostic differs from the plain communication flash
  wire diag_on = blink_cnt < 27'((BLINK_ON_CYC + BLINK_OFF_CYC) / 2);

  // Bar level, scaled per display mode
  wire [9:0] span_w = (span_hi > span_lo) ? span_hi - span_lo : 10'h001;
  wire [9:0] flow_rel = (flow > span_lo) ? flow - span_lo : 10'h000;
  wire [19:0] span_prod = 20'(flow_rel) * 20'(BAR_N);
  wire [19:0] span_lvl = span_prod / 20'(span_w);
  wire [7:0] temp_off = temp_c - 8'(TEMP_LO_C);
  wire [15:0] temp_prod = 16'(temp_off) * 16'(BAR_N);
  wire [15:0] temp_lvl = temp_prod / 16'(TEMP_HI_C - TEMP_LO_C);
  wire [9:0] dev = (flow > flow_sp) ? flow - flow_sp : flow_sp - flow;
  wire [9:0] dev_n = dev >> 6;
  wire show_temp = (state == FMD_SHOW) && btn_s2[1] && !btn_s2[0];

  genvar gi;
  generate
    for (gi = 0; gi < BAR_N; gi++) begin : g_bar
      wire span_on = span_lvl > 20'(gi);
      wire temp_on = temp_lvl > 16'(gi);
      wire up_on = flow > flow_sp && gi > BAR_MID && dev_n > 10'(gi - BAR_MID - 1);
      wire dn_on = flow < flow_sp && gi < BAR_MID && dev_n > 10'(BAR_MID - gi - 1);
      always_ff @(posedge clk_sys) begin
        if (srst || warming) begin
          bar_green[gi] <= 1'b0;
          bar_yellow[gi] <= warming && blink_on;
        end else if (show_temp) begin
          bar_green[gi] <= 1'b0;
          bar_yellow[gi] <= temp_on;
        end else if (quick_mode) begin
          bar_green[gi] <= up_on || dn_on;
          bar_yellow[gi] <= (gi == BAR_MID);
        end else begin
          bar_green[gi] <= span_on;
          bar_yellow[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      led_pwr <= 1'b0;
      led_flow <= 1'b0;
      led_temp <= 1'b0;
      led_fault <= 1'b0;
    end else begin
      led_pwr <= diag_blink ? diag_on : (bus_active ? blink_on : 1'b1);
      led_flow <= warming ? blink_on : (out_flow || loop_en || err_in[ERR_FLOW_HIGH]);
      led_temp <= out_temp || err_in[ERR_TEMP_HIGH] || err_in[ERR_TEMP_LOW];
      led_fault <= any_err || gen_dead;
    end
  end
endmodule : fmd_core

// file: logic/fmd_pkg.sv
// Shared constants for the flow monitor diagnostic and panel logic
package fmd_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 100000000;
  localparam int FIX_WAIT_S = 10;
  localparam int BLINK_ON_MS = 900;
  localparam int BLINK_OFF_MS = 100;
  localparam int TONE_ONE_HZ = 1200;
  localparam int TONE_ZERO_HZ = 2200;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int BLINK_ON_CYC = BLINK_ON_MS * CYC_PER_MS;
  localparam int BLINK_OFF_CYC = BLINK_OFF_MS * CYC_PER_MS;
  // Half period of each tone, rounded down
  localparam int TONE_ONE_HALF = CLK_HZ / (2 * TONE_ONE_HZ);
  localparam int TONE_ZERO_HALF = CLK_HZ / (2 * TONE_ZERO_HZ);
  // ****************************************
  // Error flag positions
  // ****************************************
  localparam int ERR_SPAN = 0;
  localparam int ERR_FLOW_HIGH = 1;
  localparam int ERR_TEMP_HIGH = 2;
  localparam int ERR_TEMP_LOW = 3;
  localparam int ERR_WIRE_BREAK = 4;
  localparam int ERR_SENS_SHORT = 5;
  localparam int ERR_OUT_SHORT = 6;
  localparam int ERR_LOOP = 7;
  localparam int ERR_GENERAL = 8;
  localparam int ERR_W = 9;
  // ****************************************
  // Process image and display
  // ****************************************
  localparam int PD_FLOW_MSB = 15;
  localparam int PD_FLOW_LSB = 6;
  localparam int PD_FAULT = 2;
  localparam int PD_TEMP = 1;
  localparam int PD_FLOW = 0;
  localparam int BAR_N = 10;
  localparam int BAR_MID = 4;
  localparam int TEMP_LO_C = -20;
  localparam int TEMP_HI_C = 179;
  // ****************************************
  // Parameter access
  // ****************************************
  localparam logic [7:0] PAR_SPAN_LO = 8'h00;
  localparam logic [7:0] PAR_SPAN_HI = 8'h01;
  localparam logic [7:0] PAR_FLOW_SP = 8'h02;
  localparam logic [7:0] PAR_TEMP_SP = 8'h03;
  localparam logic [7:0] PAR_STATUS = 8'h10;
  localparam logic [9:0] SPAN_LO_RST = 10'h000;
  localparam logic [9:0] SPAN_HI_RST = 10'h3ff;
  localparam logic [9:0] FLOW_SP_RST = 10'h2cc;
  localparam logic [9:0] TEMP_SP_RST = 10'h046;

  typedef enum logic [3:0] {
    FMD_WARM = 4'b0001,
    FMD_SHOW = 4'b0010,
    FMD_TEACH = 4'b0100,
    FMD_QUICK = 4'b1000
  } fmd_state_t;
endpackage : fmd_pkg

// file: logic/fmd_tone.sv
// Frequency shift tone generator for the current loop channel
`timescale 1ns/100ps
module fmd_tone
  import fmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic enable,
  input wire logic bit_in,
  output logic tone
);
  logic [15:0] cnt;
  wire [15:0] half = bit_in ? 16'(TONE_ONE_HALF) : 16'(TONE_ZERO_HALF);
  wire wrap = cnt >= half - 16'h0001;

  always_ff @(posedge clk_sys) begin
    if (srst || !enable) begin
      cnt <= 16'h0000;
      tone <= 1'b0;
    end else if (wrap) begin
      cnt <= 16'h0000;
      tone <= ~tone;
    end else begin
      cnt <= cnt + 16'h0001;
    end
  end
endmodule : fmd_tone

// file: bench/fmd_checker.sv
// Port assertions for the flow monitor core
`timescale 1ns/100ps
module fmd_checker
  import fmd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [ERR_W-1:0] err_in,
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_index,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_data,
  input wire logic hart_en,
  input wire logic hart_bit,
  input wire logic hart_tone,
  input wire logic out_flow,
  input wire logic out_temp,
  input wire logic out_fault,
  input wire logic loop_en,
  input wire logic [15:0] process_image,
  input wire logic warming
);
  // ****
  // Helpers
  // ****
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic gen_seen;
  logic [1:0] gen_d;
  logic tone_q;
  logic bit_q;
  logic clean;
  int unsigned half_cnt;
  wire toggle = hart_tone != tone_q;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      gen_seen <= 1'b0;
      gen_d <= 2'b00;
      tone_q <= 1'b0;
      clean <= 1'b0;
      half_cnt <= 0;
    end else begin
      gen_seen <= gen_seen | err_in[ERR_GENERAL];
      gen_d <= {gen_d[0], gen_seen};
      tone_q <= hart_tone;
      half_cnt <= toggle ? 1 : half_cnt + 1;
      clean <= toggle | (clean & hart_en & (hart_bit == bit_q));
    end
  end
  always_ff @(posedge clk_sys) begin
    bit_q <= hart_bit;
  end
  a_rsp_follows: assert property (req_valid |=> rsp_valid)
    else $error("request got no response");
  a_rsp_unasked: assert property (!req_valid |=> !rsp_valid)
    else $error("response without request");
  a_warm_refuse: assert property (req_valid && req_write && warming |=> !rsp_ack)
    else $error("write accepted during warm-up");
  a_status_ro: assert property (req_valid && req_write && req_index == PAR_STATUS |=> !rsp_ack)
    else $error("status write accepted");
  a_status_read: assert property (req_valid && !req_write && req_index == PAR_STATUS
    |=> rsp_ack && rsp_data[8:0] == $past(err_in)) else $error("status read wrong");
  a_warm_outs: assert property (warming |-> !out_fault && !out_flow && !out_temp && !loop_en)
    else $error("outputs active during warm-up");
  a_fault_rise: assert property ($rose(|err_in[ERR_OUT_SHORT:0]) && !warming
    |-> ##[1:3] !out_fault) else $error("fault output stayed on");
  a_image_bits: assert property (process_image[2:0] == {out_fault, out_temp, out_flow})
    else $error("image state bits wrong");
  a_image_spare: assert property (process_image[5:3] == 3'h0)
    else $error("image spare bits set");
  a_general_hold: assert property (gen_d[1] |-> !out_fault && !out_flow && !out_temp)
    else $error("outputs back on after general error");
  a_tone_half: assert property (toggle && clean
    |-> half_cnt == (bit_q ? TONE_ONE_HALF : TONE_ZERO_HALF)) else $error("tone half wrong");
  c_write_ok: cover property (req_valid && req_write && !warming);
  c_tone: cover property (toggle && clean);
  c_general: cover property (gen_d[1]);
endmodule : fmd_checker

// file: bench/fmd_master.sv
// Fieldbus master model issuing parameter requests
`timescale 1ns/100ps
module fmd_master
  import fmd_pkg::*;
(
  input wire logic clk_sys,
  output logic req_valid,
  output logic req_write,
  output logic [7:0] req_index,
  output logic [9:0] req_data,
  input wire logic rsp_valid,
  input wire logic rsp_ack,
  input wire logic [15:0] rsp_data
);
  initial begin
    req_valid = 1'b0;
    req_write = 1'b0;
    req_index = 8'hff;
    req_data = 10'h3ff;
  end
  // Request first, answer taken once it stands
  task automatic access(input logic w, input logic [7:0] idx, input logic [9:0] d,
                        output logic v, output logic ack, output logic [15:0] q);
    @(posedge clk_sys);
    #1;
    req_valid = 1'b1;
    req_write = w;
    req_index = idx;
    req_data = d;
    @(posedge clk_sys);
    #1;
    req_valid = 1'b0;
    req_index = ~idx;
    req_data = ~d;
    v = rsp_valid;
    ack = rsp_ack;
    q = rsp_data;
  endtask : access
endmodule : fmd_master

// file: bench/fmd_core_tb.sv
// Self-checking bench for the flow monitor core
`timescale 1ns/100ps
module fmd_core_tb
  import fmd_pkg::*;
();
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic btn_store = 1'b0;
  logic btn_inc = 1'b0;
  logic btn_sel = 1'b0;
  logic [9:0] flow = 10'h100;
  logic gradient_check = 1'b1;
  logic [7:0] temp_c = 8'h30;
  logic [ERR_W-1:0] err_in = '0;
  logic has_loop = 1'b1;
  logic bus_active = 1'b0;
  logic hart_en = 1'b0;
  logic hart_bit = 1'b0;
  logic req_valid, req_write, rsp_valid, rsp_ack, hart_tone, out_flow, out_temp;
  logic out_fault, loop_en, led_pwr, led_flow, led_temp, led_fault, warming;
  logic [7:0] req_index;
  logic [9:0] req_data;
  logic [15:0] rsp_data, process_image;
  logic [BAR_N-1:0] bar_green, bar_yellow;
  logic v, ack;
  logic [15:0] q;
  logic [9:0] rst_val [4] = '{SPAN_LO_RST, SPAN_HI_RST, FLOW_SP_RST, TEMP_SP_RST};
  int err_total = 0;
  int n_compared = 0;
  int cyc = 0;
  int rel = 0;
  int n;
  always #5 clk_sys = ~clk_sys;
  fmd_core #(.WARM_CYC(100), .STEP(16)) fmd_core_i (.clk_sys(clk_sys), .srst(srst),
    .btn_store(btn_store), .btn_inc(btn_inc), .btn_sel(btn_sel), .flow(flow),
    .gradient_check(gradient_check), .temp_c(temp_c), .err_in(err_in), .has_loop(has_loop),
    .bus_active(bus_active), .req_valid(req_valid), .req_write(req_write),
    .req_index(req_index), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_data(rsp_data), .hart_en(hart_en), .hart_bit(hart_bit), .hart_tone(hart_tone),
    .out_flow(out_flow), .out_temp(out_temp), .out_fault(out_fault), .loop_en(loop_en),
    .led_pwr(led_pwr), .led_flow(led_flow), .led_temp(led_temp), .led_fault(led_fault),
    .bar_green(bar_green), .bar_yellow(bar_yellow), .process_image(process_image),
    .warming(warming));
  fmd_master fmd_master_i (.clk_sys(clk_sys), .req_valid(req_valid), .req_write(req_write),
    .req_index(req_index), .req_data(req_data), .rsp_valid(rsp_valid), .rsp_ack(rsp_ack),
    .rsp_data(rsp_data));
  // ****
  // Tasks
  // ****
  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask : tick
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test
  task automatic restart();
    srst = 1'b1;
    tick(8);
    srst = 1'b0;
    rel = cyc;
  endtask : restart
  task automatic wait_warm();
    while (warming === 1'b1 && cyc - rel < 300) tick(1);
    check("warm_end", warming, 1'b0);
    check("warm_len", 16'(cyc - rel >= 100), 16'h1);
    tick(4);
  endtask : wait_warm
  task automatic half_len(input logic sync, output int len);
    logic t;
    len = 0;
    t = hart_tone;
    while (sync && hart_tone === t && len < 50000) begin tick(1); len++; end
    t = hart_tone;
    len = 0;
    while (hart_tone === t && len < 50000) begin tick(1); len++; end
  endtask : half_len
  task automatic press(input logic [2:0] b);
    {btn_store, btn_inc, btn_sel} = b;
    tick(4);
    {btn_store, btn_inc, btn_sel} = 3'b000;
    tick(4);
  endtask : press
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      stop_test();
    end
  end
  // ****
  // Scenarios
  // ****
  initial begin
    restart();
    check("warming", warming, 1'b1);
    check("fault_warm", out_fault, 1'b0);
    btn_store = 1'b1;
    btn_sel = 1'b1;
    fmd_master_i.access(1'b1, PAR_FLOW_SP, 10'h155, v, ack, q);
    check("warm_write", {v, ack}, 2'b10);
    btn_store = 1'b0;
    btn_sel = 1'b0;
    wait_warm();
    for (int i = 0; i < 4; i++) begin
      fmd_master_i.access(1'b0, 8'(i), 10'h000, v, ack, q);
      check("par_ack", {v, ack}, 2'b11);
      check("par_val", q[9:0], rst_val[i]);
    end
    fmd_master_i.access(1'b0, 8'h20, 10'h000, v, ack, q);
    check("bad_index", ack, 1'b0);
    fmd_master_i.access(1'b1, PAR_STATUS, 10'h1ff, v, ack, q);
    check("status_ro", ack, 1'b0);
    fmd_master_i.access(1'b1, PAR_FLOW_SP, 10'h155, v, ack, q);
    check("wr_ack", ack, 1'b1);
    fmd_master_i.access(1'b0, PAR_FLOW_SP, 10'h000, v, ack, q);
    check("wr_back", q[9:0], 10'h155);
    check("fault_idle", out_fault, 1'b1);
    check("loop_on", loop_en, 1'b1);
    check("flow_led", led_flow, 1'b1);
    check("pwr_steady", led_pwr, 1'b1);
    check("temp_led", led_temp, 1'b0);
    check("image", process_image, 16'h4004);
    check("bar_span", bar_green, 10'h003);
    gradient_check = 1'b0;
    press(3'b100);
    press(3'b100);
    gradient_check = 1'b1;
    tick(3);
    fmd_master_i.access(1'b0, PAR_FLOW_SP, 10'h000, v, ack, q);
    check("quick_unsteady", q[9:0], 10'h155);
    flow = 10'h180;
    press(3'b100);
    fmd_master_i.access(1'b0, PAR_FLOW_SP, 10'h000, v, ack, q);
    check("quick_store", q[9:0], 10'h180);
    check("quick_mid", bar_yellow, 10'h010);
    check("quick_none", bar_green, 10'h000);
    flow = 10'h200;
    tick(2);
    check("quick_dev", bar_green, 10'h060);
    btn_inc = 1'b1;
    tick(4);
    check("temp_bar", bar_yellow, 10'h007);
    btn_inc = 1'b0;
    tick(4);
    press(3'b001);
    btn_inc = 1'b1;
    tick(4);
    check("teach_inc", bar_yellow, 10'h010);
    btn_inc = 1'b0;
    tick(4);
    press(3'b011);
    btn_inc = 1'b1;
    tick(4);
    check("abort", bar_yellow, 10'h007);
    btn_inc = 1'b0;
    tick(4);
    flow = 10'h100;
    press(3'b001);
    press(3'b100);
    flow = 10'h300;
    press(3'b100);
    press(3'b010);
    press(3'b100);
    fmd_master_i.access(1'b0, PAR_SPAN_LO, 10'h000, v, ack, q);
    check("span_lo", q[9:0], 10'h100);
    fmd_master_i.access(1'b0, PAR_SPAN_HI, 10'h000, v, ack, q);
    check("span_hi", q[9:0], 10'h300);
    fmd_master_i.access(1'b0, PAR_TEMP_SP, 10'h000, v, ack, q);
    check("temp_sp", q[9:0], TEMP_SP_RST + 10'h010);
    flow = 10'h200;
    tick(2);
    check("bar_half", bar_green, 10'h01f);
    bus_active = 1'b1;
    for (int i = 0; i <= ERR_OUT_SHORT; i++) begin
      err_in = ERR_W'(1) << i;
      tick(4);
      check("fault_on", out_fault, 1'b0);
      check("fault_led", led_fault, 1'b1);
      fmd_master_i.access(1'b0, PAR_STATUS, 10'h000, v, ack, q);
      check("status", q[8:0], err_in);
      err_in = '0;
      tick(4);
      check("fault_off", out_fault, 1'b1);
    end
    bus_active = 1'b0;
    flow = 10'h000;
    tick(4);
    check("low_flow", out_fault, 1'b1);
    err_in[ERR_GENERAL] = 1'b1;
    tick(2);
    err_in = '0;
    tick(6);
    check("gen_hold", {out_fault, out_flow, out_temp, loop_en}, 4'h0);
    gradient_check = 1'b0;
    restart();
    tick(150);
    check("warm_grad", warming, 1'b1);
    gradient_check = 1'b1;
    wait_warm();
    check("gen_clear", out_fault, 1'b1);
    err_in[ERR_LOOP] = 1'b1;
    tick(2);
    err_in = '0;
    tick(4);
    check("loop_off", loop_en, 1'b0);
    restart();
    wait_warm();
    check("loop_stay", loop_en, 1'b0);
    hart_en = 1'b1;
    half_len(1'b1, n);
    check("tone_zero", 16'(n), 16'(TONE_ZERO_HALF));
    hart_bit = 1'b1;
    half_len(1'b0, n);
    check("tone_one", 16'(n), 16'(TONE_ONE_HALF));
    stop_test();
  end
endmodule : fmd_core_tb

bind fmd_core fmd_checker fmd_checker_i (.clk_sys(clk_sys), .srst(srst), .err_in(err_in),
  .req_valid(req_valid), .req_write(req_write), .req_index(req_index), .rsp_valid(rsp_valid),
  .rsp_ack(rsp_ack), .rsp_data(rsp_data), .hart_en(hart_en), .hart_bit(hart_bit),
  .hart_tone(hart_tone), .out_flow(out_flow), .out_temp(out_temp), .out_fault(out_fault),
  .loop_en(loop_en), .process_image(process_image), .warming(warming));
